// ---- pec_defs.vh ----
// Constants for the power event wake control block
// Overview of operation
// R1: Standby-off flag sets when standby rail drops; write one clears it.
// R2: Pulse-mode bit picks low pulse or held low level on request output.
// R3: Writing one to power-off bit deasserts request; bit reads zero.
// R4: Activation mask blocks every request source except switch-on.
// R5: Writing one enables power-good reset and clears a held level reset.
// R6: Power-good reset type: one level, zero edge.
// R7: Switch-off delay select: one 21 seconds, zero 5 seconds.
// R8: Mouse wake mode: one special key, zero signal edge.
// R9: Delay enable: switch-off deasserts after delay, else immediately.
// R10: Enabled rising edge on second ring input asserts request unless masked.
// R11: Enabled rising edge on first ring input asserts request unless masked.
// R12: Enabled modem ring detection asserts request unless masked.
// R13: Ring mode: train over 16Hz for 0.19 s, or any falling edge.
// R14: Enabled keyboard detection asserts request unless masked.
// R15: Enabled mouse detection asserts request unless masked.
// R16: Status bit 7 records keyboard detection since last read; read clears.
// R17: Status bit 6 holds the switch-off timer; clears on return to main rail. The code clears it when the standby rail rises.
// R18: Status bit 5 reads one once a switch-off event was detected.
// R19: Status bit 4 shows main supply state while standby rail is off.
// R20: Software writes zero to the reserved activate register.
// R21: Status bits 3 and 2 record ring transitions since last read.
// R22: Pulse-mode low pulse lasts a fixed number of clock cycles.
`ifndef PEC_DEFS_VH
`define PEC_DEFS_VH
`define PEC_ADDR_ACT    8'h30
`define PEC_ADDR_CFG1   8'hF0
`define PEC_ADDR_CFG2   8'hF1
`define PEC_ADDR_STAT   8'hF2
`define PEC_RST_BYTE    8'h00
// Config one fields
`define PEC_C1_SBOFF    7
`define PEC_C1_PULSE    6
`define PEC_C1_SWOFF    5
`define PEC_C1_MASK     4
`define PEC_C1_PGEN     3
`define PEC_C1_PGLVL    2
`define PEC_C1_DLY21    1
`define PEC_C1_MSKEY    0
// Config two fields
`define PEC_C2_DLYEN    6
`define PEC_C2_RI2EN    5
`define PEC_C2_RI1EN    4
`define PEC_C2_RNGEN    3
`define PEC_C2_RNGTRN   2
`define PEC_C2_KBEN     1
`define PEC_C2_MSEN     0
// Status fields
`define PEC_ST_KB       7
`define PEC_ST_HOLD     6
`define PEC_ST_SWOFF    5
`define PEC_ST_MAIN     4
`define PEC_ST_RI2      3
`define PEC_ST_RI1      2
`define PEC_ST_RNG      1
`define PEC_ST_MS       0
// Timing, clock in Hz
`define PEC_CLK_HZ      50000000
`define PEC_DLY5_S      5
`define PEC_DLY21_S     21
`define PEC_RNG_MS      190
`define PEC_RNG_HZ      16
`define PEC_DLY5_CYC    (`PEC_DLY5_S * `PEC_CLK_HZ)
`define PEC_DLY21_CYC   (`PEC_DLY21_S * `PEC_CLK_HZ)
`define PEC_RNG_CYC     ((`PEC_RNG_MS * (`PEC_CLK_HZ / 1000)))
`define PEC_RNGGAP_CYC  (`PEC_CLK_HZ / `PEC_RNG_HZ)
`define PEC_PULSE_CYC   8'h10
`define PEC_PG_CYC      8'h10
`endif

// ---- pec_top.v ----
// Power event wake control: event collection and power request logic
`default_nettype none
`include "pec_defs.vh"
module pec_top #(
  parameter DLY5_CYC   = `PEC_DLY5_CYC,
  parameter DLY21_CYC  = `PEC_DLY21_CYC,
  parameter RNG_CYC    = `PEC_RNG_CYC,
  parameter RNGGAP_CYC = `PEC_RNGGAP_CYC
) (
  // Clock and reset
  input  wire       core_clk,
  input  wire       rst_n,
  // Register port
  input  wire [7:0] reg_addr,
  input  wire [7:0] reg_wdata,
  input  wire       reg_wr,
  input  wire       reg_rd,
  output reg  [7:0] reg_rdata,
  // Wake and rail inputs, asynchronous
  input  wire       ring_indicator_first,
  input  wire       ring_indicator_second,
  input  wire       modem_ring_n,
  input  wire       kbd_detect,
  input  wire       mouse_edge,
  input  wire       mouse_key,
  input  wire       switch_on_n,
  input  wire       switch_off_n,
  input  wire       standby_rail,
  input  wire       main_rail,
  // Power outputs
  output reg        power_on_request_n,
  output reg        power_good_reset_n
);

  // Two-stage synchronisers for all ten asynchronous inputs
  wire [9:0] raw_in = {main_rail, standby_rail, switch_off_n, switch_on_n,
                       mouse_key, mouse_edge, kbd_detect, modem_ring_n,
                       ring_indicator_second, ring_indicator_first};
  reg  [9:0] meta_q;
  reg  [9:0] sync_q;
  reg  [9:0] prev_q;
  genvar gi;
  generate
    for (gi = 0; gi < 10; gi = gi + 1) begin : g_sync
      always @(posedge core_clk) begin
        if (!rst_n) begin
          meta_q[gi] <= 1'b0;
          sync_q[gi] <= 1'b0;
          prev_q[gi] <= 1'b0;
        end else begin
          meta_q[gi] <= raw_in[gi];
          sync_q[gi] <= meta_q[gi];
          prev_q[gi] <= sync_q[gi];
        end
      end
    end
  endgenerate

  // Edge decode shared by every input except main_rail, which is used as a level
  function rise;
    input cur;
    input old;
    begin
      rise = cur & ~old;
    end
  endfunction

  wire ri1_rise  = rise(sync_q[0], prev_q[0]);
  wire ri2_rise  = rise(sync_q[1], prev_q[1]);
  wire rng_fall  = rise(prev_q[2], sync_q[2]);
  wire kb_rise   = rise(sync_q[3], prev_q[3]);
  wire ms_rise   = rise(sync_q[4], prev_q[4]);
  wire mk_rise   = rise(sync_q[5], prev_q[5]);
  wire son_ev    = rise(prev_q[6], sync_q[6]);
  wire soff_ev   = rise(prev_q[7], sync_q[7]);
  wire sb_fall   = rise(prev_q[8], sync_q[8]);
  wire sb_rise   = rise(sync_q[8], prev_q[8]);
  wire main_lvl  = sync_q[9];

  // Registers
  reg [7:0] act_q;
  reg [7:0] cfg1_q;
  reg [7:0] cfg2_q;
  reg       sboff_q;
  reg       kb_st_q;
  reg       hold_q;
  reg       swoff_st_q;
  reg       ri2_st_q;
  reg       ri1_st_q;
  reg       rng_st_q;
  reg       ms_st_q;
  reg       pg_en_q;

  wire wr_act  = reg_wr && (reg_addr == `PEC_ADDR_ACT);
  wire wr_c1   = reg_wr && (reg_addr == `PEC_ADDR_CFG1);
  wire wr_c2   = reg_wr && (reg_addr == `PEC_ADDR_CFG2);
  wire wr_st   = reg_wr && (reg_addr == `PEC_ADDR_STAT);
  wire rd_st   = reg_rd && (reg_addr == `PEC_ADDR_STAT);
  wire sw_poff = wr_c1 && reg_wdata[`PEC_C1_SWOFF];
  wire pg_clr  = wr_c1 && reg_wdata[`PEC_C1_PGEN];

  // Modem ring detection: falling edge or a sustained fast train
  reg [31:0] gap_q;
  reg [31:0] trn_q;
  reg        rng_det;
  always @* begin
    if (cfg2_q[`PEC_C2_RNGTRN])
      rng_det = rng_fall && (trn_q >= RNG_CYC); // R13
    else
      rng_det = rng_fall; // R13
  end

  // Train timer restarts when an edge gap exceeds one 16Hz period
  always @(posedge core_clk) begin
    if (!rst_n) begin
      gap_q <= 32'h00000000;
      trn_q <= 32'h00000000;
    end else if (rng_fall) begin
      gap_q <= 32'h00000000;
      trn_q <= (gap_q > RNGGAP_CYC) ? 32'h00000000 : trn_q + gap_q; // R13
    end else begin
      if (gap_q <= RNGGAP_CYC)
        gap_q <= gap_q + 32'h00000001;
      else
        trn_q <= 32'h00000000;
    end
  end

  // Mouse detection picks edge or special key
  wire ms_det = cfg1_q[`PEC_C1_MSKEY] ? mk_rise : ms_rise; // R8

  // Wake sources, gated by the activation mask except switch-on
  wire src_any = (cfg2_q[`PEC_C2_RI2EN] && ri2_rise) || // R10
                 (cfg2_q[`PEC_C2_RI1EN] && ri1_rise) || // R11
                 (cfg2_q[`PEC_C2_RNGEN] && rng_det) ||  // R12
                 (cfg2_q[`PEC_C2_KBEN]  && kb_rise) ||  // R14
                 (cfg2_q[`PEC_C2_MSEN]  && ms_det);     // R15
  wire wake = son_ev || (src_any && !cfg1_q[`PEC_C1_MASK]); // R4

  // Config and status registers; event set wins over clear
  always @(posedge core_clk) begin
    if (!rst_n) begin
      act_q      <= `PEC_RST_BYTE;
      cfg1_q     <= `PEC_RST_BYTE;
      cfg2_q     <= `PEC_RST_BYTE;
      sboff_q    <= 1'b0;
      kb_st_q    <= 1'b0;
      hold_q     <= 1'b0;
      swoff_st_q <= 1'b0;
      ri2_st_q   <= 1'b0;
      ri1_st_q   <= 1'b0;
      rng_st_q   <= 1'b0;
      ms_st_q    <= 1'b0;
      pg_en_q    <= 1'b0;
    end else begin
      if (wr_act)
        act_q <= reg_wdata; // R20
      if (wr_c1)
        cfg1_q <= {1'b0, reg_wdata[6], 1'b0, reg_wdata[4], 1'b0,
                   reg_wdata[2:0]}; // R3
      if (wr_c2)
        cfg2_q <= {1'b0, reg_wdata[6:0]};
      if (sb_fall)
        sboff_q <= 1'b1; // R1
      else if (wr_c1 && reg_wdata[`PEC_C1_SBOFF])
        sboff_q <= 1'b0; // R1
      if (pg_clr)
        pg_en_q <= 1'b1; // R5
      kb_st_q  <= kb_rise  | (kb_st_q  & ~rd_st); // R16
      ri2_st_q <= ri2_rise | (ri2_st_q & ~rd_st); // R21
      ri1_st_q <= ri1_rise | (ri1_st_q & ~rd_st); // R21
      rng_st_q <= rng_det  | (rng_st_q & ~rd_st);
      ms_st_q  <= ms_det   | (ms_st_q  & ~rd_st);
      if (soff_ev)
        swoff_st_q <= 1'b1; // R18
      else if (son_ev)
        swoff_st_q <= 1'b0;
      if (sb_rise)
        hold_q <= 1'b0; // R17
      else if (wr_st)
        hold_q <= reg_wdata[`PEC_ST_HOLD]; // R17
    end
  end

  // Switch-off delay machine
  localparam [2:0] S_ON   = 3'b001;
  localparam [2:0] S_WAIT = 3'b010;
  localparam [2:0] S_OFF  = 3'b100;
  reg [2:0]  st_q;
  reg [31:0] dly_q;
  reg [7:0]  pls_q;
  reg        req_q;
  wire [31:0] dly_lim = cfg1_q[`PEC_C1_DLY21] ? DLY21_CYC : DLY5_CYC; // R7

  // Request state; a software power-off overrides any pending wake
  always @(posedge core_clk) begin
    if (!rst_n) begin
      st_q  <= S_OFF;
      dly_q <= 32'h00000000;
      req_q <= 1'b0;
    end else begin
      case (st_q)
        S_OFF: begin
          if (wake && !sw_poff) begin
            st_q  <= S_ON;
            req_q <= 1'b1;
          end
        end
        S_ON: begin
          if (sw_poff) begin
            st_q  <= S_OFF; // R3
            req_q <= 1'b0;
          end else if (soff_ev) begin
            if (cfg2_q[`PEC_C2_DLYEN]) begin
              st_q  <= S_WAIT; // R9
              dly_q <= 32'h00000000;
            end else begin
              st_q  <= S_OFF; // R9
              req_q <= 1'b0;
            end
          end
        end
        S_WAIT: begin
          if (sw_poff || dly_q >= dly_lim - 1) begin
            st_q  <= S_OFF; // R9
            req_q <= 1'b0;
          end else if (!hold_q) begin
            dly_q <= dly_q + 32'h00000001; // R17
          end
        end
        default: begin
          st_q  <= S_OFF;
          req_q <= 1'b0;
        end
      endcase
    end
  end

  // Request pin: level or fixed low pulse on assertion
  always @(posedge core_clk) begin
    if (!rst_n) begin
      pls_q              <= 8'h00;
      power_on_request_n <= 1'b1;
    end else begin
      // A power-off cuts a running pulse short as well
      if (sw_poff)
        pls_q <= 8'h00; // R3
      else if (st_q == S_OFF && wake)
        pls_q <= `PEC_PULSE_CYC; // R22
      else if (pls_q != 8'h00)
        pls_q <= pls_q - 8'h01;
      if (cfg1_q[`PEC_C1_PULSE])
        power_on_request_n <= (pls_q == 8'h00); // R2
      else
        power_on_request_n <= ~req_q; // R2
    end
  end

  // Power-good reset: edge type pulses, level type holds until cleared
  reg [7:0] pg_cnt_q;
  reg       pg_hold_q;
  always @(posedge core_clk) begin
    if (!rst_n) begin
      pg_cnt_q           <= 8'h00;
      pg_hold_q          <= 1'b0;
      power_good_reset_n <= 1'b1;
    end else begin
      if (pg_en_q && wake && st_q == S_OFF) begin
        if (cfg1_q[`PEC_C1_PGLVL])
          pg_hold_q <= 1'b1; // R6
        else
          pg_cnt_q <= `PEC_PG_CYC; // R6
      end else begin
        if (pg_clr)
          pg_hold_q <= 1'b0; // R5
        if (pg_cnt_q != 8'h00)
          pg_cnt_q <= pg_cnt_q - 8'h01;
      end
      power_good_reset_n <= ~(pg_hold_q || pg_cnt_q != 8'h00);
    end
  end

  // Read data, one cycle after the strobe; unmapped reads zero
  always @(posedge core_clk) begin
    if (!rst_n) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      case (reg_addr)
        `PEC_ADDR_ACT:  reg_rdata <= act_q;
        `PEC_ADDR_CFG1: reg_rdata <= {sboff_q, cfg1_q[6:0]};
        `PEC_ADDR_CFG2: reg_rdata <= cfg2_q;
        `PEC_ADDR_STAT: reg_rdata <= {kb_st_q, hold_q, swoff_st_q,
                                      main_lvl & ~sync_q[8], // R19
                                      ri2_st_q, ri1_st_q, rng_st_q, ms_st_q};
        default:        reg_rdata <= 8'h00;
      endcase
    end else begin
      reg_rdata <= 8'h00;
    end
  end

endmodule // pec_top
`default_nettype wire

// ---- pec_checker.sv ----
// Port checker for the power event wake control block
`default_nettype none
module pec_checker (
  // Clock and reset
  input wire logic       core_clk,
  input wire logic       rst_n,
  // Register port
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic       reg_wr,
  input wire logic       reg_rd,
  input wire logic [7:0] reg_rdata,
  // Pins
  input wire logic       ring_indicator_first,
  input wire logic       switch_off_n,
  input wire logic       power_on_request_n
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] c1_q;
  logic [7:0] c2_q;
  // Shadow of the config writes, so modes are known
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      c1_q <= 8'h00;
      c2_q <= 8'h00;
    end else begin
      if (reg_wr && reg_addr == 8'hF0) c1_q <= reg_wdata;
      if (reg_wr && reg_addr == 8'hF1) c2_q <= reg_wdata;
    end
  end
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  rd_slot_a: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
    else $error("read data outside slot");
  wo_bits_a: assert property (reg_rd && reg_addr == 8'hF0 |=>
    !reg_rdata[5] && !reg_rdata[3]) else $error("write-only bit reads one");
  sw_off_a: assert property (reg_wr && reg_addr == 8'hF0 &&
    reg_wdata[5] |-> ##[1:3] power_on_request_n) else $error("no power-off");
  req_hold_a: assert property ($fell(power_on_request_n) |=>
    !power_on_request_n [*8]) else $error("request too short");
  ring_wake_a: assert property (c2_q[4] && !c1_q[4] && !c1_q[6] &&
    $rose(ring_indicator_first) |-> ##[3:8] !power_on_request_n)
    else $error("ring did not wake");
  mask_block_a: assert property (c1_q[4] && power_on_request_n &&
    $rose(ring_indicator_first) |=> power_on_request_n [*8])
    else $error("masked ring woke");
  off_now_a: assert property (!c2_q[6] && $fell(switch_off_n) |->
    ##[3:8] power_on_request_n) else $error("late switch-off");
  off_late_a: assert property (c2_q[6] && !c1_q[6] &&
    $fell(switch_off_n) && !power_on_request_n |=>
    !power_on_request_n [*8]) else $error("delay skipped");
  cover property (c1_q[4] && $rose(ring_indicator_first));
  cover property (c2_q[6] && $fell(switch_off_n));
  cover property (c1_q[6] && $fell(power_on_request_n));
endmodule // pec_checker
`default_nettype wire

// ---- pec_partner.sv ----
// Far side model: ring lines, switches and supply rails
`default_nettype none
module pec_partner (
  // Clock, reset and request from the block
  input  wire logic       core_clk,
  input  wire logic       rst_n,
  input  wire logic       power_on_request_n,
  // One-cycle tap requests from the bench, a bit per pin
  input  wire logic [8:0] tap_go,
  // Event pins and rails
  output var  logic [8:0] ev,
  output var  logic       main_rail
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [8:0] away_q;
  logic [2:0] left_q;
  // Idle: active-low lines and standby rail high; a tapped pin leaves
  // idle for four cycles, long enough for the synchroniser
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      ev     <= 9'h1C4;
      away_q <= 9'h000;
      left_q <= 3'h0;
    end else if (left_q == 3'h1) begin
      ev     <= ev ^ away_q;
      left_q <= 3'h0;
    end else if (left_q != 3'h0) begin
      left_q <= left_q - 3'h1;
    end else if (tap_go != 9'h000) begin
      ev     <= ev ^ tap_go;
      away_q <= tap_go;
      left_q <= 3'h4;
    end
  end
  // Supply follows the request a cycle late
  always_ff @(posedge core_clk) begin
    if (!rst_n)
      main_rail <= 1'b0;
    else
      main_rail <= !power_on_request_n;
  end
endmodule // pec_partner
`default_nettype wire

// ---- test_power_event_wake_control.sv ----
// Bench for the power event wake control block
`default_nettype none
module test_power_event_wake_control;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {
    logic [7:0] c1;
    logic [7:0] c2;
    logic [3:0] ev;
    logic [7:0] st;
    logic       wk;
  } pec_row_t;
  logic       core_clk, rst_n, reg_wr, reg_rd, main_rail;
  logic [7:0] reg_addr, reg_wdata, reg_rdata;
  logic       power_on_request_n, power_good_reset_n;
  logic [8:0] ev, tap_go;
  int         n_mismatch, n_tests, cyc, n, m;
  pec_row_t   rows[10];
  logic [7:0] ra[5] = '{8'h30, 8'hF0, 8'hF1, 8'hF2, 8'h55};
  logic [7:0] s1[3] = '{8'h00, 8'h02, 8'h00};
  logic [7:0] s2[3] = '{8'h50, 8'h50, 8'h10};
  int         lo[3] = '{50, 90, 0};
  pec_top #(.DLY5_CYC(50), .DLY21_CYC(90), .RNG_CYC(40), .RNGGAP_CYC(20))
  i_pec_top (
    .core_clk(core_clk), .rst_n(rst_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .ring_indicator_first(ev[0]),
    .ring_indicator_second(ev[1]), .modem_ring_n(ev[2]),
    .kbd_detect(ev[3]), .mouse_edge(ev[4]), .mouse_key(ev[5]),
    .switch_on_n(ev[6]), .switch_off_n(ev[7]), .standby_rail(ev[8]),
    .main_rail(main_rail), .power_on_request_n(power_on_request_n),
    .power_good_reset_n(power_good_reset_n));
  pec_partner i_pec_partner (.core_clk(core_clk), .rst_n(rst_n),
    .power_on_request_n(power_on_request_n), .tap_go(tap_go), .ev(ev),
    .main_rail(main_rail));
  task automatic chk(input logic [7:0] g, e);
    n_tests++;
    if (g !== e) begin
      n_mismatch++;
      $display("unexpected at %0t: got %h want %h", $time, g, e);
    end
  endtask
  task automatic wr(input logic [7:0] a, d);
    @(posedge core_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask
  // Data stand only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, e, k);
    @(posedge core_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    @(negedge core_clk);
    chk(reg_rdata & k, e);
  endtask
  // One pin leaves idle for four cycles; returns once it is back
  task automatic tap(input int k);
    @(posedge core_clk);
    tap_go <= 9'h001 << k;
    @(posedge core_clk);
    tap_go <= 9'h000;
    repeat (4) @(posedge core_clk);
  endtask
  task automatic till(input int lim, output int c);
    c = 0;
    while (power_on_request_n !== 1'b1 && c < lim) begin
      @(negedge core_clk);
      c++;
    end
  endtask
  task automatic wrap_up();
    $display("mismatches %0d, checks %0d", n_mismatch, n_tests);
    if (n_mismatch == 0 && n_tests > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  initial begin
    core_clk = 1'b0;
    forever #10 core_clk = ~core_clk;
  end
  // Cut a hang short
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (cyc == 6000) begin
      n_mismatch++;
      wrap_up();
    end
  end
  initial begin
    rows = '{'{8'h00, 8'h10, 4'h0, 8'h04, 1'b1},
      '{8'h00, 8'h00, 4'h0, 8'h04, 1'b0}, '{8'h00, 8'h20, 4'h1, 8'h08, 1'b1},
      '{8'h00, 8'h08, 4'h2, 8'h02, 1'b1}, '{8'h00, 8'h02, 4'h3, 8'h80, 1'b1},
      '{8'h00, 8'h00, 4'h3, 8'h80, 1'b0}, '{8'h00, 8'h01, 4'h4, 8'h01, 1'b1},
      '{8'h01, 8'h01, 4'h5, 8'h01, 1'b1}, '{8'h10, 8'h10, 4'h0, 8'h04, 1'b0},
      '{8'h10, 8'h00, 4'h6, 8'h00, 1'b1}};
    {rst_n, reg_wr, reg_rd, reg_addr, reg_wdata, tap_go} = 28'h0;
    {n_mismatch, n_tests, cyc} = '0;
    repeat (10) @(posedge core_clk);
    rst_n <= 1'b1;
    foreach (ra[i]) rd(ra[i], 8'h00, 8'hEF);
    wr(8'h30, 8'h00);
    // Wake sources, enables, mask and sticky status
    foreach (rows[i]) begin
      wr(8'hF0, rows[i].c1);
      wr(8'hF1, rows[i].c2);
      tap(rows[i].ev);
      repeat (8) @(posedge core_clk);
      chk({7'h00, power_on_request_n}, {7'h00, !rows[i].wk});
      rd(8'hF2, rows[i].st, 8'hCF);
      rd(8'hF2, 8'h00, 8'hCF);
      wr(8'hF0, rows[i].c1 | 8'h20);
      repeat (3) @(posedge core_clk);
      chk({7'h00, power_on_request_n}, 8'h01);
    end
    // Pulse request and edge power-good, counted together
    wr(8'hF1, 8'h10);
    wr(8'hF0, 8'h48);
    {n, m} = '0;
    fork
      tap(0);
      repeat (40) begin
        @(negedge core_clk);
        if (!power_on_request_n) n++;
        if (!power_good_reset_n) m++;
      end
    join
    chk(8'(n), 8'h10);
    chk(8'(m), 8'h10);
    wr(8'hF0, 8'h20);
    wr(8'hF0, 8'h0C);
    tap(0);
    repeat (20) @(posedge core_clk);
    chk({7'h00, power_good_reset_n}, 8'h00);
    wr(8'hF0, 8'h0C);
    repeat (3) @(posedge core_clk);
    chk({7'h00, power_good_reset_n}, 8'h01);
    // Switch-off: 5 and 21 delays, then immediate
    foreach (s1[i]) begin
      wr(8'hF0, s1[i]);
      wr(8'hF1, s2[i]);
      tap(0);
      repeat (10) @(posedge core_clk);
      fork
        tap(7);
        till(200, n);
      join
      chk({7'h00, n >= lo[i] && n <= lo[i] + 12}, 8'h01);
      rd(8'hF2, 8'h20, 8'h20);
    end
    // Held timer resumes only once standby rail returns
    wr(8'hF0, 8'h00);
    wr(8'hF1, 8'h50);
    tap(0);
    wr(8'hF2, 8'h40);
    tap(7);
    till(100, n);
    chk({7'h00, power_on_request_n}, 8'h00);
    // Status read lands while standby is low and main is still on
    fork
      tap(8);
      till(100, n);
      begin
        repeat (3) @(posedge core_clk);
        rd(8'hF2, 8'h10, 8'h10);
      end
    join
    chk({7'h00, power_on_request_n}, 8'h01);
    wr(8'hF0, 8'h00);
    rd(8'hF0, 8'h80, 8'h80);
    wr(8'hF0, 8'h80);
    rd(8'hF0, 8'h00, 8'h80);
    wrap_up();
  end
endmodule // test_power_event_wake_control
bind pec_top pec_checker i_pec_checker (
  .core_clk(core_clk), .rst_n(rst_n), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_rdata(reg_rdata), .ring_indicator_first(ring_indicator_first),
  .switch_off_n(switch_off_n), .power_on_request_n(power_on_request_n));
`default_nettype wire
